// [design/wdt_control.sv]
// watchdog timer with its control register on the special function register bus
`timescale 1ns/10ps
module wdt_control
  import wdt_pkg::*;
(
  input  wire logic            i_clk,
  input  wire logic            i_reset,
  input  wire wdt_sfr_req_type i_sfr,
  output logic [7:0]           o_rdata,
  output logic                 o_rdata_valid,
  output logic                 o_wdt_reset
);
  logic                 hit_wr;
  logic                 hit_rd;
  logic                 active_q;
  logic                 lock_q;
  logic [2:0]           interval_q;
  logic [2:0]           dis_win_q;
  logic [WDT_CNT_W-1:0] count_q;
  logic [WDT_CNT_W-1:0] limit;
  logic                 key_reload;
  logic                 key_disable;
  logic                 expire;
  logic [7:0]           wr_quiet_q;

  assign hit_wr = i_sfr.wr && (i_sfr.addr == WDT_CONTROL_ADDR);
  assign hit_rd = i_sfr.rd && (i_sfr.addr == WDT_CONTROL_ADDR);
  assign key_reload = hit_wr && (i_sfr.wdata == WDT_KEY_RELOAD);
  // second key must land while the window from the first is still open
  assign key_disable = hit_wr && (i_sfr.wdata == WDT_KEY_DIS_SECOND) && (dis_win_q != 3'h0) && !lock_q;
  // timeout length 4^(3+interval) = 2^(6+2*interval)
  assign limit = WDT_CNT_W'(1) << (6 + 2 * int'(interval_q));
  assign expire = active_q && (count_q == limit - WDT_CNT_W'(1));

  // disable window: opened by the first key, counts down each clock
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dis_win_q <= 3'h0;
    end else if (hit_wr && (i_sfr.wdata == WDT_KEY_DIS_FIRST)) begin
      dis_win_q <= WDT_DIS_WIN_CNT;
    end else if (dis_win_q != 3'h0) begin
      dis_win_q <= dis_win_q - 3'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      lock_q <= 1'b0;
    end else if (hit_wr && (i_sfr.wdata == WDT_KEY_LOCK)) begin
      lock_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      active_q <= WDT_ACTIVE_RESET;
    end else if (key_reload) begin
      active_q <= 1'b1;
    end else if (key_disable) begin
      active_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      interval_q <= WDT_INTERVAL_RESET;
    end else if (hit_wr && !i_sfr.wdata[WDT_SELECT_BIT]) begin
      interval_q <= i_sfr.wdata[2:0];
    end
  end

  // counter restarts on every reload so a late kick still gets a full period
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      count_q <= '0;
    end else if (key_reload || !active_q || expire) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + WDT_CNT_W'(1);
    end
  end

  // reset pulse is registered; the system reset it triggers clears this block
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_wdt_reset <= 1'b0;
    end else begin
      o_wdt_reset <= expire && !key_reload;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata       <= 8'h00;
      o_rdata_valid <= 1'b0;
    end else begin
      o_rdata_valid <= hit_rd;
      if (hit_rd) begin
        o_rdata <= {3'h0, active_q, 1'b0, interval_q};
      end
    end
  end

  // quiet-time count feeds only the timeout check below; saturates so it never wraps
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_quiet_q <= 8'h00;
    end else if (hit_wr) begin
      wr_quiet_q <= 8'h00;
    end else if (wr_quiet_q != 8'hFF) begin
      wr_quiet_q <= wr_quiet_q + 8'h01;
    end
  end

  a_lock_holds: assert property (@(posedge i_clk) disable iff (i_reset)
      lock_q
      |=> lock_q)
    else $error("lock released before reset");

  a_lock_sets: assert property (@(posedge i_clk) disable iff (i_reset)
      hit_wr && i_sfr.wdata == WDT_KEY_LOCK
      |=> lock_q)
    else $error("lock key did not lock");

  a_lock_blocks: assert property (@(posedge i_clk) disable iff (i_reset)
      lock_q && hit_wr && i_sfr.wdata == WDT_KEY_DIS_SECOND && active_q
      |=> active_q)
    else $error("disable taken while locked");

  a_lock_no_enable: assert property (@(posedge i_clk) disable iff (i_reset)
      hit_wr && i_sfr.wdata == WDT_KEY_LOCK && !active_q
      |=> !active_q)
    else $error("lock key started the watchdog");

  a_window_open: assert property (@(posedge i_clk) disable iff (i_reset)
      hit_wr && i_sfr.wdata == WDT_KEY_DIS_FIRST
      |=> dis_win_q == WDT_DIS_WIN_CNT)
    else $error("first disable key did not open the window");

  // a second key one clock too late must be ignored
  a_late_second: assert property (@(posedge i_clk) disable iff (i_reset)
      (hit_wr && i_sfr.wdata == WDT_KEY_DIS_FIRST)
      ##1 (!(hit_wr && i_sfr.wdata == WDT_KEY_DIS_FIRST))[*4]
      ##1 (hit_wr && i_sfr.wdata == WDT_KEY_DIS_SECOND && active_q)
      |=> active_q)
    else $error("late disable key stopped the watchdog");

  a_window_edge: assert property (@(posedge i_clk) disable iff (i_reset)
      (hit_wr && i_sfr.wdata == WDT_KEY_DIS_FIRST)
      ##4 (hit_wr && i_sfr.wdata == WDT_KEY_DIS_SECOND && !lock_q)
      |=> !active_q)
    else $error("disable key on the last window clock was ignored");

  a_disable_stops: assert property (@(posedge i_clk) disable iff (i_reset)
      key_disable && !key_reload
      |=> !active_q)
    else $error("timely disable did not stop the watchdog");

  a_reload_starts: assert property (@(posedge i_clk) disable iff (i_reset)
      key_reload
      |=> active_q && count_q == 0)
    else $error("reload key did not start the watchdog");

  a_reload_kick: assert property (@(posedge i_clk) disable iff (i_reset)
      key_reload
      |=> !o_wdt_reset)
    else $error("reset pulse despite a reload");

  a_status_read: assert property (@(posedge i_clk) disable iff (i_reset)
      hit_rd
      |=> o_rdata_valid && o_rdata[WDT_STATUS_BIT] == $past(active_q))
    else $error("status bit wrong on read");

  a_rdata_fixed: assert property (@(posedge i_clk) disable iff (i_reset)
      o_rdata_valid
      |-> o_rdata[7:5] == 3'h0 && !o_rdata[3])
    else $error("unused read bits not zero");

  a_valid_source: assert property (@(posedge i_clk) disable iff (i_reset)
      o_rdata_valid
      |-> $past(hit_rd))
    else $error("read valid without a read");

  a_interval_read: assert property (@(posedge i_clk) disable iff (i_reset)
      hit_rd
      |=> o_rdata[2:0] == $past(interval_q))
    else $error("interval wrong on read");

  a_rdata_hold: assert property (@(posedge i_clk) disable iff (i_reset)
      !hit_rd
      |=> $stable(o_rdata))
    else $error("read data changed without a read");

  a_interval_write: assert property (@(posedge i_clk) disable iff (i_reset)
      hit_wr && !i_sfr.wdata[WDT_SELECT_BIT]
      |=> interval_q == $past(i_sfr.wdata[2:0]))
    else $error("interval not updated");

  a_interval_keep: assert property (@(posedge i_clk) disable iff (i_reset)
      !(hit_wr && !i_sfr.wdata[WDT_SELECT_BIT])
      |=> $stable(interval_q))
    else $error("interval changed without a write");

  // only interval 0 is checked; longer intervals are too slow to reach in a short run
  a_expire_reset: assert property (@(posedge i_clk) disable iff (i_reset)
      key_reload && interval_q == 3'h0
      |-> ##64 !o_wdt_reset
      ##1 (o_wdt_reset || wr_quiet_q < 8'h40))
    else $error("timeout pulse not sixty-four clocks after reload");

  a_reset_cause: assert property (@(posedge i_clk) disable iff (i_reset)
      o_wdt_reset
      |-> $past(active_q))
    else $error("watchdog reset while inactive");

  a_pulse_single: assert property (@(posedge i_clk) disable iff (i_reset)
      o_wdt_reset
      |=> !o_wdt_reset)
    else $error("watchdog reset longer than one clock");

  a_idle_quiet: assert property (@(posedge i_clk) disable iff (i_reset)
      !active_q
      |=> !o_wdt_reset)
    else $error("reset pulse from an idle watchdog");
endmodule

// [shared/wdt_pkg.sv]
// package of constants and types for the watchdog timer control block
// Summary of operation
// - Writing 0xA5 to the control register enables the watchdog if it is idle and reloads its counter.
// - The watchdog stops only when 0xDE is followed by 0xAD within four system clocks; other timing leaves it running.
// - Writing 0xFF locks out the disable sequence until the next reset.
// - Bit 4 of a control register read shows whether the watchdog is running.
// - A write with bit 7 clear updates the 3-bit timeout interval in bits 2 to 0.
// - A control register read returns the programmed interval in its low three bits.
// - After reset the interval field reads back as binary 111.
package wdt_pkg;
  localparam logic [7:0] WDT_CONTROL_ADDR   = 8'hFF;
  localparam logic [7:0] WDT_KEY_RELOAD     = 8'hA5;
  localparam logic [7:0] WDT_KEY_DIS_FIRST  = 8'hDE;
  localparam logic [7:0] WDT_KEY_DIS_SECOND = 8'hAD;
  localparam logic [7:0] WDT_KEY_LOCK       = 8'hFF;
  localparam int         WDT_DIS_WINDOW     = 4;
  localparam logic [2:0] WDT_DIS_WIN_CNT    = 3'h4;
  localparam int         WDT_STATUS_BIT     = 4;
  localparam int         WDT_SELECT_BIT     = 7;
  localparam logic [2:0] WDT_INTERVAL_RESET = 3'h7;
  localparam logic       WDT_ACTIVE_RESET   = 1'b0;
  localparam int         WDT_CNT_W          = 21;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wdt_sfr_req_type;
endpackage

// [tb/tb_top.sv]
// testbench for the watchdog timer control block
`timescale 1ns/10ps
module tb_top;
  import wdt_pkg::*;
  logic            i_clk           = 1'b0;
  logic            i_reset         = 1'b1;
  wdt_sfr_req_type sfr             = '0;
  logic [7:0]      rdata;
  logic            rvalid;
  logic            wdt_rst;
  int              errors          = 0;
  int              samples_checked = 0;
  int              n;
  always #20 i_clk = ~i_clk;
  wdt_control DUT (.i_clk(i_clk), .i_reset(i_reset), .i_sfr(sfr), .o_rdata(rdata), .o_rdata_valid(rvalid),
                   .o_wdt_reset(wdt_rst));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1 sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    #1 sfr.wr = 1'b0;
  endtask
  // unmapped reads expect no valid pulse, so their data is not compared
  task automatic rd(input logic [7:0] a, input logic v, input logic [7:0] exp);
    @(posedge i_clk);
    #1 sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    #1 sfr.rd = 1'b0;
    chk("rdata_valid", {7'h00, rvalid}, {7'h00, v});
    if (v) chk("rdata", rdata, exp);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // about 170 cycles are expected; this allows over seventeen times that
  initial begin
    #120000;
    errors++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    #1 i_reset = 1'b0;
    rd(WDT_CONTROL_ADDR, 1'b1, 8'h07);
    wr(WDT_CONTROL_ADDR, 8'h00);
    rd(WDT_CONTROL_ADDR, 1'b1, 8'h00);
    wr(8'hFE, 8'h03);
    rd(8'hFE, 1'b0, 8'h00);
    rd(WDT_CONTROL_ADDR, 1'b1, 8'h00);
    $display("test done: reset and interval");
    wr(WDT_CONTROL_ADDR, WDT_KEY_RELOAD);
    rd(WDT_CONTROL_ADDR, 1'b1, 8'h10);
    repeat (30) @(posedge i_clk);
    #1 chk("early_timeout", {7'h00, wdt_rst}, 8'h00);
    wr(WDT_CONTROL_ADDR, WDT_KEY_RELOAD);
    n = 0;
    while (wdt_rst !== 1'b1 && n < 200) begin
      @(posedge i_clk);
      #1 n++;
    end
    // interval 0 times out four to the third power clocks after the reload edge
    chk("timeout_cycles", n[7:0], 8'h40);
    @(posedge i_clk);
    #1 chk("reset_pulse", {7'h00, wdt_rst}, 8'h00);
    $display("test done: reload and timeout");
    wr(WDT_CONTROL_ADDR, WDT_KEY_DIS_FIRST);
    wr(WDT_CONTROL_ADDR, WDT_KEY_DIS_SECOND);
    rd(WDT_CONTROL_ADDR, 1'b1, 8'h00);
    wr(WDT_CONTROL_ADDR, WDT_KEY_RELOAD);
    // second key five clocks after the first is one too late
    wr(WDT_CONTROL_ADDR, WDT_KEY_DIS_FIRST);
    repeat (3) @(posedge i_clk);
    wr(WDT_CONTROL_ADDR, WDT_KEY_DIS_SECOND);
    rd(WDT_CONTROL_ADDR, 1'b1, 8'h10);
    // four clocks after the first is the last one that still counts
    wr(WDT_CONTROL_ADDR, WDT_KEY_DIS_FIRST);
    repeat (2) @(posedge i_clk);
    wr(WDT_CONTROL_ADDR, WDT_KEY_DIS_SECOND);
    rd(WDT_CONTROL_ADDR, 1'b1, 8'h00);
    wr(WDT_CONTROL_ADDR, WDT_KEY_RELOAD);
    $display("test done: disable timing");
    wr(WDT_CONTROL_ADDR, WDT_KEY_LOCK);
    wr(WDT_CONTROL_ADDR, WDT_KEY_DIS_FIRST);
    wr(WDT_CONTROL_ADDR, WDT_KEY_DIS_SECOND);
    rd(WDT_CONTROL_ADDR, 1'b1, 8'h10);
    $display("test done: lock");
    @(posedge i_clk);
    #1 i_reset = 1'b1;
    repeat (2) @(posedge i_clk);
    #1 i_reset = 1'b0;
    rd(WDT_CONTROL_ADDR, 1'b1, 8'h07);
    wr(WDT_CONTROL_ADDR, WDT_KEY_RELOAD);
    wr(WDT_CONTROL_ADDR, WDT_KEY_DIS_FIRST);
    wr(WDT_CONTROL_ADDR, WDT_KEY_DIS_SECOND);
    rd(WDT_CONTROL_ADDR, 1'b1, 8'h07);
    wr(WDT_CONTROL_ADDR, WDT_KEY_LOCK);
    rd(WDT_CONTROL_ADDR, 1'b1, 8'h07);
    $display("test done: reset clears lock");
    stop_test();
  end
endmodule
